// ==== pkg/dlk_pkg.sv ====
// Purpose: Shared constants and types for the display link serdes block.
// Assumes: System clock of 40 MHz; pixel clock sampled as a plain input.
// Notes:   Lane mapping and lock timing are held here so both halves agree.
package dlk_pkg;
  // ----------------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_W = 28;
  localparam int unsigned LANES = 4;
  localparam int unsigned SLOTS = 7;
  localparam int unsigned COLOUR_W = 24;
  localparam int unsigned LINE_SYNC_BIT = 24;
  localparam int unsigned FRAME_SYNC_BIT = 25;
  localparam int unsigned VALID_BIT = 26;
  localparam int unsigned SPARE_BIT = 27;
  // One rise per word, at slot 0, so the receiver never restarts mid-word
  localparam logic [SLOTS-1:0] FWD_CLK_PATTERN = 7'h0f;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam longint unsigned SYS_CLK_HZ = 40000000;
  localparam longint unsigned LOCK_TIME_MS = 10;
  localparam longint unsigned LOCK_CYCLES =
    (LOCK_TIME_MS * SYS_CLK_HZ + 999) / 1000;
  localparam int unsigned LOCK_W = 32;
  localparam logic [LOCK_W-1:0] LOCK_DEFAULT = LOCK_CYCLES[LOCK_W-1:0];
  localparam logic [LOCK_W-1:0] REF_IDLE_MAX = 32'h0000_0040;
  localparam int unsigned SLOT_W = 3;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 3'h6;
  localparam logic [SLOT_W-1:0] SLOT_ZERO = 3'h0;
  typedef enum logic [1:0] {DLK_OFF, DLK_LOCKING, DLK_RUN} dlk_state_t;
endpackage

// ==== logic/dlk_lock_timer.sv ====
// Purpose: Lock timer that models a PLL settle window.
// Assumes: Start is a level; restarting clears the count.
// Notes:   Used twice, once for each half of the link.
`timescale 1ns/100ps
module dlk_lock_timer #(
  parameter logic [dlk_pkg::LOCK_W-1:0] LOCK_LEN = dlk_pkg::LOCK_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic run,
  output logic locked
);
  import dlk_pkg::*;
  logic [LOCK_W-1:0] count_reg;

  // Count while the reference runs; any stop restarts the settle window
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
      locked <= 1'b0;
    end else if (!run) begin
      count_reg <= '0;
      locked <= 1'b0;
    end else if (count_reg >= LOCK_LEN - 1'b1) begin
      locked <= 1'b1;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end
endmodule

// ==== logic/dlk_serdes.sv ====
// Purpose: Display link transmitter and receiver, 28 bits over 4 lanes.
// Assumes: Pixel and forwarded clocks are sampled by clk_sys; the serial
//          slot rate is modelled one slot per clk_sys cycle.
// Notes:   Bit slots advance once per clk_sys cycle, with no divided enable.
// How it works
// - The transmitter turns a 28-bit parallel word into four serial lanes.
// - A fifth lane carries a clock locked to the pixel clock.
// - Each pixel clock cycle all 28 inputs are captured once and sent.
// - The receiver rebuilds the 28-bit word from four lanes and that clock.
// - A word holds 24 colour bits and four control bits.
// - At 65 MHz each lane carries 455 Mbps, seven bits per pixel cycle.
// - Each pixel period holds exactly seven bit slots per lane; here seven clk_sys slots follow each pixel rise.
// - Inputs are sampled on the rising edge of the pixel clock.
// - The rising edge of the recovered clock strobes the output word.
// - Serial output is not trusted until the transmit lock time of 10 ms.
// - Recovered data is not trusted until the receive lock time of 10 ms.
// - With power_down_n low all outputs float and the block idles; here serial_out_en and parallel_out_en drop, the locks clear, data holds.
// - The control bits stand for line sync, frame sync and data enable.
`timescale 1ns/100ps
module dlk_serdes #(
  parameter logic [dlk_pkg::LOCK_W-1:0] LOCK_LEN = dlk_pkg::LOCK_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic power_down_n,
  input wire logic pixel_clock_in,
  input wire logic [dlk_pkg::WORD_W-1:0] parallel_data_in,
  output logic [dlk_pkg::LANES-1:0] serial_lane_out,
  output logic serial_clock_out,
  output logic serial_out_en,
  output logic tx_locked,
  input wire logic [dlk_pkg::LANES-1:0] serial_lane_in,
  input wire logic serial_clock_in,
  output logic [dlk_pkg::WORD_W-1:0] parallel_data_out,
  output logic [dlk_pkg::COLOUR_W-1:0] colour_out,
  output logic line_sync,
  output logic frame_sync,
  output logic data_valid_strobe,
  output logic spare_control,
  output logic recovered_clock_out,
  output logic parallel_out_en,
  output logic rx_locked
);
  import dlk_pkg::*;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic pd_meta, pd_sync, pix_meta, pix_sync, pix_prev;
  logic fwd_meta, fwd_sync, fwd_prev;
  logic [LANES-1:0] lane_meta, lane_sync;
  logic [WORD_W-1:0] din_meta, din_sync;
  logic pix_rise, fwd_rise, tx_lock_w, rx_lock_w;

  // Two stages on every pin; the first stage feeds only the second
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pd_meta <= 1'b0;
      pd_sync <= 1'b0;
      pix_meta <= 1'b0;
      pix_sync <= 1'b0;
      pix_prev <= 1'b0;
      fwd_meta <= 1'b0;
      fwd_sync <= 1'b0;
      fwd_prev <= 1'b0;
      lane_meta <= '0;
      lane_sync <= '0;
      din_meta <= '0;
      din_sync <= '0;
    end else begin
      pd_meta <= power_down_n;
      pd_sync <= pd_meta;
      pix_meta <= pixel_clock_in;
      pix_sync <= pix_meta;
      pix_prev <= pix_sync;
      fwd_meta <= serial_clock_in;
      fwd_sync <= fwd_meta;
      fwd_prev <= fwd_sync;
      lane_meta <= serial_lane_in;
      lane_sync <= lane_meta;
      din_meta <= parallel_data_in;
      din_sync <= din_meta;
    end
  end

  assign pix_rise = pix_sync & ~pix_prev;
  assign fwd_rise = fwd_sync & ~fwd_prev;

  // ----------------------------------------------------------------------
  // Lock timers
  // ----------------------------------------------------------------------
  // Settle windows only run while powered and the reference toggles
  logic pix_alive, fwd_alive;
  logic [LOCK_W-1:0] pix_idle_reg, fwd_idle_reg;
  localparam logic [LOCK_W-1:0] IDLE_MAX = REF_IDLE_MAX;

  // Lose the reference after a long gap with no rising edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pix_idle_reg <= IDLE_MAX;
      fwd_idle_reg <= IDLE_MAX;
    end else begin
      if (pix_rise) pix_idle_reg <= '0;
      else if (pix_idle_reg != IDLE_MAX) pix_idle_reg <= pix_idle_reg + 1'b1;
      if (fwd_rise) fwd_idle_reg <= '0;
      else if (fwd_idle_reg != IDLE_MAX) fwd_idle_reg <= fwd_idle_reg + 1'b1;
    end
  end

  assign pix_alive = pd_sync && (pix_idle_reg != IDLE_MAX);
  assign fwd_alive = pd_sync && (fwd_idle_reg != IDLE_MAX);

  dlk_lock_timer #(.LOCK_LEN(LOCK_LEN)) u_tx_lock (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(pix_alive),
    .locked(tx_lock_w)
  );

  dlk_lock_timer #(.LOCK_LEN(LOCK_LEN)) u_rx_lock (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(fwd_alive),
    .locked(rx_lock_w)
  );

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------
  logic [WORD_W-1:0] tx_word_reg;
  logic [SLOT_W-1:0] tx_slot_reg;
  logic tx_busy_reg;

  // Capture the whole word on the pixel rising edge, then walk 7 slots
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_word_reg <= '0;
      tx_slot_reg <= SLOT_ZERO;
      tx_busy_reg <= 1'b0;
    end else if (!pd_sync) begin
      tx_busy_reg <= 1'b0;
      tx_slot_reg <= SLOT_ZERO;
    end else if (pix_rise) begin
      tx_word_reg <= din_sync;
      tx_slot_reg <= SLOT_ZERO;
      tx_busy_reg <= 1'b1;
    end else if (tx_busy_reg) begin
      if (tx_slot_reg == SLOT_LAST) tx_busy_reg <= 1'b0;
      else tx_slot_reg <= tx_slot_reg + 1'b1;
    end
  end

  // Lane l carries word bits l*7 .. l*7+6, slot 0 first
  logic [LANES-1:0] tx_bits;
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      tx_bits[l] = tx_word_reg[l*SLOTS + int'(tx_slot_reg)];
    end
  end

  // Drive lanes and forwarded clock; float all when powered down
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      serial_lane_out <= '0;
      serial_clock_out <= 1'b0;
      serial_out_en <= 1'b0;
      tx_locked <= 1'b0;
    end else begin
      serial_out_en <= pd_sync;
      tx_locked <= tx_lock_w;
      // Gate with power too, so no slot leaks out once the enable drops
      serial_lane_out <= (pd_sync && tx_busy_reg) ? tx_bits : '0;
      serial_clock_out <= pd_sync && tx_busy_reg
        && FWD_CLK_PATTERN[tx_slot_reg];
    end
  end

  // ----------------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------------
  logic [WORD_W-1:0] rx_shift_reg;
  logic [SLOT_W-1:0] rx_slot_reg;
  logic rx_busy_reg, rx_done_reg;

  // Forwarded clock rise marks slot 0; gather one bit per lane per slot
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_shift_reg <= '0;
      rx_slot_reg <= SLOT_ZERO;
      rx_busy_reg <= 1'b0;
      rx_done_reg <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      if (!pd_sync) begin
        rx_busy_reg <= 1'b0;
      end else if (fwd_rise || rx_busy_reg) begin
        for (int l = 0; l < LANES; l++) begin
          rx_shift_reg[l*SLOTS + int'(fwd_rise ? SLOT_ZERO : rx_slot_reg)]
            <= lane_sync[l];
        end
        if (fwd_rise) begin
          rx_slot_reg <= SLOT_ZERO + 1'b1;
          rx_busy_reg <= 1'b1;
        end else if (rx_slot_reg == SLOT_LAST) begin
          rx_busy_reg <= 1'b0;
          rx_done_reg <= 1'b1;
        end else begin
          rx_slot_reg <= rx_slot_reg + 1'b1;
        end
      end
    end
  end

  // Word changes with clock low, then clock pulses at the next forwarded clock rise as strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      parallel_data_out <= '0;
      colour_out <= '0;
      line_sync <= 1'b0;
      frame_sync <= 1'b0;
      data_valid_strobe <= 1'b0;
      spare_control <= 1'b0;
      recovered_clock_out <= 1'b0;
      parallel_out_en <= 1'b0;
      rx_locked <= 1'b0;
    end else begin
      parallel_out_en <= pd_sync;
      rx_locked <= rx_lock_w;
      recovered_clock_out <= 1'b0;
      if (rx_done_reg) begin
        parallel_data_out <= rx_shift_reg;
        colour_out <= rx_shift_reg[COLOUR_W-1:0];
        line_sync <= rx_shift_reg[LINE_SYNC_BIT];
        frame_sync <= rx_shift_reg[FRAME_SYNC_BIT];
        data_valid_strobe <= rx_shift_reg[VALID_BIT];
        spare_control <= rx_shift_reg[SPARE_BIT];
      end else if (fwd_rise) begin
        recovered_clock_out <= pd_sync;
      end
    end
  end
endmodule

// ==== verification/dlk_sva.sv ====
// Purpose: Port checker for the display link serdes.
// Assumes: Single clk_sys domain, nrst low resets.
// Notes:   Bound into dlk_serdes at the foot of this file.
`timescale 1ns/100ps
module dlk_sva #(
  parameter logic [dlk_pkg::LOCK_W-1:0] LOCK_LEN = 16
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic power_down_n,
  input wire logic serial_clock_out,
  input wire logic serial_out_en,
  input wire logic tx_locked,
  input wire logic [dlk_pkg::WORD_W-1:0] parallel_data_out,
  input wire logic [dlk_pkg::COLOUR_W-1:0] colour_out,
  input wire logic line_sync,
  input wire logic frame_sync,
  input wire logic data_valid_strobe,
  input wire logic spare_control,
  input wire logic recovered_clock_out,
  input wire logic parallel_out_en,
  input wire logic rx_locked
);
  import dlk_pkg::*;
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  logic [LOCK_W-1:0] up_cnt_reg;

  // Cycles since power was last requested; saturates, never wraps
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      up_cnt_reg <= '0;
    end else if (!power_down_n) begin
      up_cnt_reg <= '0;
    end else if (up_cnt_reg != '1) begin
      up_cnt_reg <= up_cnt_reg + 1'b1;
    end
  end

  // One rise per word, at slot 0, high for four slots in all, then a low one
  a_fwd_clock_tail: assert property (
    disable iff (!nrst || !power_down_n)
    $rose(serial_clock_out) |->
    serial_clock_out [*4] ##1 !serial_clock_out)
    else $error("bad clock slots");
  a_clk_needs_en: assert property (
    serial_clock_out |-> serial_out_en) else $error("clock while off");
  a_strobe_pulse: assert property (
    recovered_clock_out |=> !recovered_clock_out) else $error("long strobe");
  a_fields_split: assert property (
    {spare_control, data_valid_strobe, frame_sync, line_sync, colour_out}
    == parallel_data_out) else $error("field split wrong");
  // Sync plus register gives the enables three cycles; five is slack
  a_pd_floats: assert property (
    !power_down_n [*5] |-> !serial_out_en && !parallel_out_en)
    else $error("drives while powered down");
  a_pd_unlocks: assert property (
    !power_down_n [*8] |-> !tx_locked && !rx_locked)
    else $error("lock kept in power down");
  // A lock may only show after a full settle window of powered cycles
  a_tx_lock_wait: assert property (
    $rose(tx_locked) |-> up_cnt_reg >= LOCK_LEN)
    else $error("tx lock too early");
  a_rx_lock_wait: assert property (
    $rose(rx_locked) |-> up_cnt_reg >= LOCK_LEN)
    else $error("rx lock too early");
  c_strobe: cover property (rx_locked && recovered_clock_out);
  c_pd: cover property (!power_down_n [*8]);
  c_relock: cover property ($rose(tx_locked));
endmodule
bind dlk_serdes dlk_sva #(.LOCK_LEN(LOCK_LEN)) dlk_sva_inst (.clk_sys,
  .nrst, .power_down_n, .serial_clock_out, .serial_out_en, .tx_locked,
  .parallel_data_out, .colour_out, .line_sync, .frame_sync,
  .data_valid_strobe, .spare_control, .recovered_clock_out,
  .parallel_out_en, .rx_locked);

// ==== verification/dlk_far_end.sv ====
// Purpose: Far side: pixel source and cable back to the receiver.
// Assumes: Pixel clock runs free at 200 ns.
// Notes:   An undriven lane reads back inverted, never a held value.
`timescale 1ns/100ps
module dlk_far_end (
  output logic pix,
  input wire logic [dlk_pkg::LANES-1:0] lane_tx,
  input wire logic clk_tx,
  input wire logic en_tx,
  output logic [dlk_pkg::LANES-1:0] lane_rx,
  output logic clk_rx
);
  import dlk_pkg::*;
  // Phase offset keeps pixel edges off the clk_sys edges; the period is
  // stretched to 200 ns because each serial slot takes one clk_sys cycle
  initial begin
    pix = 1'b0;
    #13;
    forever #100 pix = ~pix;
  end
  // Loopback cable; floating lanes must not look like good data
  assign lane_rx = en_tx ? lane_tx : ~lane_tx;
  assign clk_rx = en_tx ? clk_tx : ~clk_tx;
endmodule

// ==== verification/tb_lvds_display_link_28bit_serdes.sv ====
// Purpose: Self-checking loopback bench for the display link serdes.
// Assumes: Lanes return through the far-end model.
// Notes:   Lock length is cut to 16 cycles to keep the run short.
`timescale 1ns/100ps
module tb_lvds_display_link_28bit_serdes;
  import dlk_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic power_down_n = 1'b1;
  logic pix;
  logic armed = 1'b0;
  logic [WORD_W-1:0] din = 28'h0;
  logic [WORD_W-1:0] dout;
  logic [WORD_W-1:0] e;
  logic [LANES-1:0] lane_tx;
  logic [LANES-1:0] lane_rx;
  logic clk_tx, clk_rx, en_tx, tx_lk, rx_lk, rclk, pen;
  logic [COLOUR_W-1:0] col;
  logic ls, fs, dv, sp;
  logic [WORD_W-1:0] wq[$];
  time tq[$];
  logic [31:0] rs = 32'h1afd;
  int err_total = 0;
  int n_compared = 0;
  always #12.5 clk_sys = ~clk_sys;
  dlk_serdes #(.LOCK_LEN(32'h10)) dlk_serdes_inst (.clk_sys(clk_sys),
    .nrst(nrst), .power_down_n(power_down_n), .pixel_clock_in(pix),
    .parallel_data_in(din), .serial_lane_out(lane_tx),
    .serial_clock_out(clk_tx), .serial_out_en(en_tx), .tx_locked(tx_lk),
    .serial_lane_in(lane_rx), .serial_clock_in(clk_rx),
    .parallel_data_out(dout), .colour_out(col), .line_sync(ls),
    .frame_sync(fs), .data_valid_strobe(dv), .spare_control(sp),
    .recovered_clock_out(rclk),
    .parallel_out_en(pen), .rx_locked(rx_lk));
  dlk_far_end dlk_far_end_inst (.pix(pix), .lane_tx(lane_tx),
    .clk_tx(clk_tx), .en_tx(en_tx), .lane_rx(lane_rx), .clk_rx(clk_rx));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [WORD_W-1:0] got,
                     input logic [WORD_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Wait for both locks, then let the pipe fill before checking words
  task automatic wait_lock();
    int n;
    n = 0;
    while (!(tx_lk === 1'b1 && rx_lk === 1'b1) && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    chk({27'h0, n < 400}, 28'h1);
    chk({26'h0, en_tx, pen}, 28'h3);
    repeat (24) @(posedge clk_sys);
    #2 armed = 1'b1;
  endtask
  // New random word mid-period, so it is steady at the pixel rise
  always @(negedge pix) begin
    @(posedge clk_sys);
    rs = xs(rs);
    din <= #2 rs[WORD_W-1:0];
  end
  always @(posedge pix) begin
    wq.push_back(din);
    tq.push_back($time);
  end
  // Strobed word is the newest sent 12+ cycles back; pipe is ~16 deep
  always @(posedge clk_sys) begin
    if (armed && rclk === 1'b1) begin
      for (int i = wq.size() - 1; i >= 0; i--) begin
        if (tq[i] <= $time - 300) begin
          e = wq[i];
          break;
        end
      end
      chk(dout, e);
      chk({sp, dv, fs, ls, col}, e);
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    chk({23'h0, en_tx, tx_lk, rx_lk, pen, rclk}, 28'h0);
    #2 nrst = 1'b1;
    wait_lock();
    repeat (320) @(posedge clk_sys);
    // Power down mid-word, then the link must relock and resume
    #2 armed = 1'b0;
    power_down_n = 1'b0;
    repeat (12) @(posedge clk_sys);
    chk({24'h0, en_tx, pen, tx_lk, rx_lk}, 28'h0);
    #2 power_down_n = 1'b1;
    wait_lock();
    repeat (320) @(posedge clk_sys);
    close_out();
  end
  // Run needs about 20 us; a hang is cut at 100 us
  initial begin
    #100000;
    err_total++;
    close_out();
  end
endmodule
